// ---- dv/bam_apg_model.sv ----
// ****************************************
// Antenna pulse source with latch strobes
// ****************************************
module bam_pulse_model #(
  parameter int unsigned LATCH_GAP = 1000
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic go,
  input wire logic [15:0] count,
  input wire logic [1:0] spacing,
  input wire logic latch_en,
  output logic azimuth_change_pulse,
  output logic azimuth_reference_pulse,
  output logic latch_pulse,
  output logic busy
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] left;
  logic [1:0] tick;
  int unsigned lcnt;
  // Reference pulse closes each revolution
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      azimuth_change_pulse <= 1'b0;
      azimuth_reference_pulse <= 1'b0;
      busy <= 1'b0;
      left <= 16'h0;
      tick <= 2'h0;
    end else begin
      azimuth_change_pulse <= 1'b0;
      azimuth_reference_pulse <= 1'b0;
      if (go && !busy) begin
        busy <= 1'b1;
        left <= count;
        tick <= 2'h0;
      end else if (busy) begin
        tick <= tick + 2'h1;
        if (tick == spacing - 2'h1) begin
          tick <= 2'h0;
          if (left == 16'h0) begin
            azimuth_reference_pulse <= 1'b1;
            busy <= 1'b0;
          end else begin
            azimuth_change_pulse <= 1'b1;
            left <= left - 16'h1;
          end
        end
      end
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lcnt <= 0;
      latch_pulse <= 1'b0;
    end else begin
      lcnt <= (lcnt == LATCH_GAP - 1) ? 0 : lcnt + 1;
      latch_pulse <= latch_en && (lcnt == LATCH_GAP - 1);
    end
  end
endmodule

// ---- dv/bit_alarm_status_monitor_test.sv ----
module bit_alarm_status_monitor_test;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {
    logic signed [15:0] p5, n5, p15, n15;
    logic signed [7:0] t;
    logic cf;
    logic [2:0] exp;
  } bam_eq_row_s;
  bam_eq_row_s eq_tab [11] = '{
    '{5000, -5000, 15000, -15000, 25, 0, 0},
    '{5250, -5000, 15000, -15000, 25, 0, 0},
    '{5251, -5000, 15000, -15000, 25, 0, 1},
    '{5000, -5251, 15000, -15000, 25, 0, 1},
    '{5000, -4750, 15500, -15000, 25, 0, 0},
    '{5000, -5000, 15501, -15000, 25, 0, 1},
    '{5000, -5000, 15000, -14499, 25, 0, 1},
    '{5000, -5000, 15000, -15000, 0, 0, 0},
    '{5000, -5000, 15000, -15000, -1, 0, 2},
    '{5000, -5000, 15000, -15000, 65, 0, 0},
    '{5000, -5000, 15000, -15000, 66, 1, 6}};
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, go = 1'b0;
  logic latch_en = 1'b0, cf = 1'b0, ibe = 1'b0;
  logic lb = 1'b0, cs = 1'b0, ps = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, v;
  logic signed [15:0] p5 = 5000, n5 = -5000, p15 = 15000, n15 = -15000;
  logic signed [7:0] tc = 8'sh19;
  logic [15:0] cnt = 16'h0;
  logic [1:0] sp = 2'h3, ph = 2'h3, am = 2'h3, rbe = 2'h0;
  logic [9:0] dlt = '1, omni = '1, sumu = '1;
  logic [17:0] tlvl = '1;
  logic [11:0] so = '1, aux = '1;
  logic [15:0] dsr = '1;
  logic chg, refp, lp, mbusy, pa, ta, ca, ra, ga, comb, tbusy;
  int num_errors = 0, checks_done = 0, g, k;
  logic [31:0] e;

  always #5 clk = ~clk;

  bam_pulse_model model_u (.clk(clk), .rst(rst), .go(go), .count(cnt),
    .spacing(sp), .latch_en(latch_en), .azimuth_change_pulse(chg),
    .azimuth_reference_pulse(refp), .latch_pulse(lp), .busy(mbusy));

  // Short second so antenna windows fit the run
  bam_monitor #(.SEC_CYCLES(3000), .BIT_CYCLES(16), .NUM_GEN(2)) dut_u (
    .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .p5_mv(p5), .n5_mv(n5), .p15_mv(p15), .n15_mv(n15),
    .temp_c(tc), .comp_fail(cf), .azimuth_change_pulse(chg),
    .azimuth_reference_pulse(refp), .latch_pulse(lp), .dlt_up_ok(dlt),
    .omni_up_ok(omni), .sum_up_ok(sumu), .tlvl_ok(tlvl), .so_ok(so),
    .dsr_ok(dsr), .aux_ok(aux), .phase_ok(ph), .ampl_ok(am),
    .reply_bit_err(rbe),
    .inter_bit_err(ibe), .load_bad(lb), .cal_sum_bad(cs),
    .prog_sum_bad(ps), .power_alarm(pa), .temp_alarm(ta), .cal_alarm(ca),
    .rotation_rate_alarm(ra), .pgen_alarm(ga),
    .combined_antenna_alarm(comb), .test_busy(tbusy));

  // ****************************************
  // Bus and check tasks
  // ****************************************
  task automatic results();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
    input string msg);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp,
    input string msg);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, exp, msg);
  endtask
  // Waits for the pulse source and the self test to go quiet
  task automatic wait_idle(input int n);
    int i;
    repeat (2) @(posedge clk);
    for (i = 0; i < n && (mbusy || tbusy); i++) @(posedge clk);
    if (mbusy || tbusy) begin
      num_errors++;
      $display("CHECK FAILED %0t timeout", $time);
      results();
    end
    repeat (4) @(posedge clk);
    #1;
  endtask
  task automatic rev(input logic [15:0] c, input logic [1:0] s);
    @(posedge clk);
    cnt <= c;
    sp <= s;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    wait_idle(60000);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    #1 chk({pa, ta, ca, ra, ga, comb, tbusy}, 32'h0, "reset out");
    rchk(8'h00, 32'h0000_0004, "reset ctrl");
    wreg(8'h24, 32'hffff_ffff);
    rchk(8'h24, 32'h0, "unmapped");
    rchk(8'h00, 32'h0000_0004, "ctrl kept");
    foreach (eq_tab[i]) begin
      @(posedge clk);
      p5 <= eq_tab[i].p5;
      n5 <= eq_tab[i].n5;
      p15 <= eq_tab[i].p15;
      n15 <= eq_tab[i].n15;
      tc <= eq_tab[i].t;
      cf <= eq_tab[i].cf;
      wreg(8'h00, 32'h0000_0006);
      repeat (3) @(posedge clk);
      #1 chk({ca, ta, pa}, eq_tab[i].exp, "equip");
      rchk(8'h04, eq_tab[i].exp, "equip reg");
    end
    p5 <= 5400;
    tc <= 8'sh19;
    cf <= 1'b0;
    repeat (5) @(posedge clk);
    #1 chk({ca, ta, pa}, 32'h6, "equip hold");
    p5 <= 5000;
    for (k = -1; k < 14; k++) begin
      g = k & 1;
      dlt <= '1; omni <= '1; sumu <= '1; tlvl <= '1; so <= '1; dsr <= '1;
      aux <= '1; ph <= 2'h3; am <= 2'h3; lb <= 1'b0; cs <= 1'b0;
      ps <= 1'b0;
      @(posedge clk);
      case (k)
        0: dlt[g*5+4] <= 1'b0;
        1: omni[g*5+4] <= 1'b0;
        2: sumu[g*5+4] <= 1'b0;
        3: tlvl[g*9+8] <= 1'b0;
        4: so[g*6+5] <= 1'b0;
        5: dsr[g*8+7] <= 1'b0;
        6: aux[g*6+5] <= 1'b0;
        7: ph[g] <= 1'b0;
        8: am[g] <= 1'b0;
        9: lb <= 1'b1;
        12: cs <= 1'b1;
        13: ps <= 1'b1;
        default: ;
      endcase
      wreg(8'h00, 32'h0000_0005);
      if (k < 0) rchk(8'h00, 32'h0000_0014, "busy bit");
      @(posedge clk);
      rbe[g] <= (k == 10);
      ibe <= (k == 11);
      @(posedge clk);
      rbe <= 2'h0;
      ibe <= 1'b0;
      wait_idle(200);
      e = (k < 0) ? 32'h0 : 32'h1 << (13 - k);
      // Shared faults may show on both sets, so for them only the own set is judged
      rchk(g ? 8'h0c : 8'h08, e, "bit own");
      if (k < 9 || k == 10) rchk(g ? 8'h08 : 8'h0c, 32'h0, "bit other");
    end
    rev(16'h0, 2'h3);
    rev(16'd4096, 2'h3);
    chk({ra, ga, comb}, 32'h0, "ratio 4096");
    rev(16'd4099, 2'h3);
    chk({ra, ga, comb}, 32'h3, "ratio off");
    rev(16'd1300, 2'h3);
    chk({ra, comb}, 32'h3, "fast spin");
    wreg(8'h00, 32'h0);
    repeat (3) @(posedge clk);
    #1 chk({ra, comb}, 32'h2, "masked");
    wreg(8'h00, 32'h0000_0004);
    rev(16'd16386, 2'h2);
    chk({ra, ga, comb}, 32'h0, "ratio 16386");
    rchk(8'h10, 32'h0, "rev count");
    wreg(8'h00, 32'h0000_000c);
    latch_en <= 1'b1;
    repeat (7000) @(posedge clk);
    #1 chk({ga, comb}, 32'h0, "latch ok");
    latch_en <= 1'b0;
    repeat (7000) @(posedge clk);
    #1 chk({ga, comb}, 32'h3, "latch missing");
    results();
  end
endmodule

// ---- verilog/bam_bit_eval.sv ----
`include "bam_consts.svh"
// Folds per-step attenuator and modulator results into failure flags
module bam_bit_eval
  import bam_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic load,
  bam_step_if.eval st,
  input wire logic load_bad,
  input wire logic ber_reply_fail,
  input wire logic ber_inter_fail,
  input wire logic cal_sum_bad,
  input wire logic prog_sum_bad,
  output bam_bit_s flags
);
  bam_bit_s next_flags;
  assign next_flags.delta_upconverter = ~&st.dlt_up_ok;
  assign next_flags.omni_upconverter = ~&st.omni_up_ok;
  assign next_flags.sum_upconverter = ~&st.sum_up_ok;
  assign next_flags.target_level_attenuator = ~&st.tlvl_ok;
  assign next_flags.sum_omni_ratio = ~&st.so_ok;
  assign next_flags.delta_sum_ratio_attenuator = ~&st.dsr_ok;
  assign next_flags.aux_delta_sum_attenuator = ~&st.aux_ok;
  assign next_flags.phase_mod = ~st.phase_ok;
  assign next_flags.pulse_amplitude_modulator = ~st.ampl_ok;
  assign next_flags.load_bad = load_bad;
  assign next_flags.ber_reply = ber_reply_fail;
  assign next_flags.ber_inter = ber_inter_fail;
  assign next_flags.cal_flash = cal_sum_bad;
  assign next_flags.prog_rom = prog_sum_bad;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flags <= '0;
    end else if (load) begin
      flags <= next_flags;
    end
  end

  a_hold_flags: assert property (@(posedge clk) disable iff (rst)
    !load |=> $stable(flags)) else $error("flags changed without load");
  a_delta_fail: assert property (@(posedge clk) disable iff (rst)
    load && !(&st.dlt_up_ok) |=> flags.delta_upconverter)
    else $error("upconverter fault not flagged");
  a_tlvl_fail: assert property (@(posedge clk) disable iff (rst)
    load |=> flags.target_level_attenuator == !$past(&st.tlvl_ok))
    else $error("target level flag wrong");
endmodule

// ---- verilog/bam_consts.svh ----
`ifndef BAM_CONSTS_SVH
`define BAM_CONSTS_SVH

// Register offsets (byte addresses, one word each)
`define BAM_REG_CTRL 8'h00
`define BAM_REG_EQUIP 8'h04
`define BAM_REG_BIT0 8'h08
`define BAM_REG_BIT1 8'h0c
`define BAM_REG_ROT 8'h10
`define BAM_REG_LIMIT 8'h14
// Control fields
`define BAM_CTRL_SELFTEST 0
`define BAM_CTRL_EQUIP_EVAL 1
`define BAM_CTRL_ANT_EN 2
`define BAM_CTRL_PHASED 3
`define BAM_CTRL_RST 32'h0000_0004
// Supply readings in millivolts, signed 16 bit
`define BAM_P5_MV 16'sd5000
`define BAM_N5_MV -16'sd5000
`define BAM_P15_MV 16'sd15000
`define BAM_N15_MV -16'sd15000
`define BAM_TOL5_MV 16'sd250
`define BAM_TOL15_MV 16'sd500
// Temperature window, whole degrees C, signed 8 bit
`define BAM_TEMP_MIN 8'sd0
`define BAM_TEMP_MAX 8'sd65
// Rotation window in rev per minute
`define BAM_RPM_MIN 4
`define BAM_RPM_MAX 15
// Pulse ratio targets
`define BAM_RATIO_LO 4096
`define BAM_RATIO_HI 16384
`define BAM_RATIO_TOL 2
`define BAM_LATCH_MIN 2
// Timing
`define BAM_CLK_HZ 100000000
// Error limit: 1e-4 means one error per 10000 bits
`define BAM_BER_DEN 10000
`endif

// ---- verilog/bam_monitor.sv ----
`include "bam_consts.svh"
// Overview of operation
// - Every indicator is one bit; zero is good, one is a fault.
// - Power alarm when any of four supply readings leaves tolerance.
// - Temperature alarm outside 0 to 65 degrees C.
// - Calibration alarm when sum temperature compensation fails; nonblocking.
// - Rotation alarm when rotation rate leaves 4 to 15 rev per minute.
// - Generator alarm unless 4096 or 16384 change pulses per rev, within 2.
// - Phased array source needs two latch pulses per second, else alarm.
// - Rotation alarm drives combined antenna alarm.
// - Pulse generator alarm drives combined antenna alarm.
// - Antenna alarms disabled never block normal operation.
// - Two reply generators each keep a full set of test flags.
// - Five steps checked per upconverter; any bad step sets its flag.
// - Nine target level steps checked; any bad step fails.
// - Six sum to omni steps checked; any bad step fails.
// - Delta to sum steps checked; any bad step fails.
// - Aux delta to sum six steps checked; any bad step fails.
// - Phase modulator and amplitude modulator each get a flag.
// - Load failure flag when logic pattern download fails.
// - Reply loop error rate test fails above one in ten thousand.
// - Interrogation loop error rate test fails above one in ten thousand.
// - Calibration sector checksum mismatch sets its flag.
// - Program sector checksum mismatch sets its flag.
// - Five volt rails within 0.25 V, fifteen volt within 0.5 V.
// - Self test request runs full sequence, updates flags at completion.
module bam_monitor
  import bam_pkg::*;
#(
  parameter int unsigned SEC_CYCLES = `BAM_CLK_HZ,
  parameter int unsigned BIT_CYCLES = 16,
  parameter int unsigned NUM_GEN = 2
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic signed [15:0] p5_mv,
  input wire logic signed [15:0] n5_mv,
  input wire logic signed [15:0] p15_mv,
  input wire logic signed [15:0] n15_mv,
  input wire logic signed [7:0] temp_c,
  input wire logic comp_fail,
  input wire logic azimuth_change_pulse,
  input wire logic azimuth_reference_pulse,
  input wire logic latch_pulse,
  input wire logic [5*2-1:0] dlt_up_ok,
  input wire logic [5*2-1:0] omni_up_ok,
  input wire logic [5*2-1:0] sum_up_ok,
  input wire logic [9*2-1:0] tlvl_ok,
  input wire logic [6*2-1:0] so_ok,
  input wire logic [8*2-1:0] dsr_ok,
  input wire logic [6*2-1:0] aux_ok,
  input wire logic [1:0] phase_ok,
  input wire logic [1:0] ampl_ok,
  input wire logic [1:0] reply_bit_err,
  input wire logic inter_bit_err,
  input wire logic load_bad,
  input wire logic cal_sum_bad,
  input wire logic prog_sum_bad,
  output logic power_alarm,
  output logic temp_alarm,
  output logic cal_alarm,
  output logic rotation_rate_alarm,
  output logic pgen_alarm,
  output logic combined_antenna_alarm,
  output logic test_busy
);
  // ************************************************************
  // Control register
  // ************************************************************
  logic [31:0] ctrl;
  logic start_pulse;
  logic equip_pulse;
  wire ant_en = ctrl[`BAM_CTRL_ANT_EN];
  wire phased = ctrl[`BAM_CTRL_PHASED];
  wire wr_ctrl = wr && (addr == `BAM_REG_CTRL);

  // Strobe bits self clear; enable and source bits stay
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl <= `BAM_CTRL_RST;
      start_pulse <= 1'b0;
      equip_pulse <= 1'b0;
    end else begin
      start_pulse <= wr_ctrl && wdata[`BAM_CTRL_SELFTEST];
      equip_pulse <= wr_ctrl && wdata[`BAM_CTRL_EQUIP_EVAL];
      if (wr_ctrl) begin
        ctrl <= {28'h0, wdata[3:2], 2'b00};
      end
    end
  end

  // ************************************************************
  // Equipment alarms
  // ************************************************************
  function automatic logic out_tol(input logic signed [15:0] v,
      input logic signed [15:0] nom, input logic signed [15:0] tol);
    out_tol = (v > nom + tol) || (v < nom - tol);
  endfunction
  wire next_power = out_tol(p5_mv, `BAM_P5_MV, `BAM_TOL5_MV) ||
    out_tol(n5_mv, `BAM_N5_MV, `BAM_TOL5_MV) ||
    out_tol(p15_mv, `BAM_P15_MV, `BAM_TOL15_MV) ||
    out_tol(n15_mv, `BAM_N15_MV, `BAM_TOL15_MV);
  wire next_temp = (temp_c < `BAM_TEMP_MIN) || (temp_c > `BAM_TEMP_MAX);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      power_alarm <= 1'b0;
      temp_alarm <= 1'b0;
      cal_alarm <= 1'b0;
    end else if (equip_pulse) begin
      power_alarm <= next_power;
      temp_alarm <= next_temp;
      cal_alarm <= comp_fail;
    end
  end

  // ************************************************************
  // Antenna pulse monitor
  // ************************************************************
  localparam longint unsigned MIN_CYC = longint'(SEC_CYCLES) * 60;
  localparam longint unsigned REV_MAX = MIN_CYC / `BAM_RPM_MIN;
  localparam longint unsigned REV_MIN = MIN_CYC / `BAM_RPM_MAX;
  localparam int PW = $clog2(REV_MAX + 2);
  localparam logic [PW-1:0] REV_MAX_C = PW'(REV_MAX);
  localparam logic [PW-1:0] REV_MIN_C = PW'(REV_MIN);
  localparam int SW = $clog2(SEC_CYCLES + 1);
  localparam logic [SW-1:0] SEC_C = SW'(SEC_CYCLES - 1);
  logic [PW-1:0] rev_cnt;
  logic [15:0] chg_cnt;
  logic [SW-1:0] sec_cnt;
  logic [1:0] latch_cnt;
  logic rot_bad;
  logic ratio_bad;
  logic latch_bad;
  logic ref_seen;
  wire rev_over = rev_cnt >= REV_MAX_C;
  wire sec_end = sec_cnt == SEC_C;
  wire ratio_ok =
    (chg_cnt >= 16'(`BAM_RATIO_LO - `BAM_RATIO_TOL) &&
     chg_cnt <= 16'(`BAM_RATIO_LO + `BAM_RATIO_TOL)) ||
    (chg_cnt >= 16'(`BAM_RATIO_HI - `BAM_RATIO_TOL) &&
     chg_cnt <= 16'(`BAM_RATIO_HI + `BAM_RATIO_TOL));
  wire [15:0] chg_inc = (chg_cnt == 16'hffff) ? chg_cnt : chg_cnt + 16'h1;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rev_cnt <= '0;
      chg_cnt <= '0;
      rot_bad <= 1'b0;
      ratio_bad <= 1'b0;
      ref_seen <= 1'b0;
    end else if (azimuth_reference_pulse) begin
      rev_cnt <= '0;
      chg_cnt <= '0;
      ref_seen <= 1'b1;
      if (ref_seen) begin
        rot_bad <= (rev_cnt < REV_MIN_C) || rev_over;
        ratio_bad <= !ratio_ok;
      end
    end else begin
      // Stalled antenna is caught without waiting for a reference
      if (rev_over) begin
        rot_bad <= 1'b1;
      end else begin
        rev_cnt <= rev_cnt + PW'(1);
      end
      if (azimuth_change_pulse) begin
        chg_cnt <= chg_inc;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sec_cnt <= '0;
      latch_cnt <= '0;
      latch_bad <= 1'b0;
    end else if (sec_end) begin
      sec_cnt <= '0;
      latch_cnt <= '0;
      latch_bad <= phased && (latch_cnt < 2'(`BAM_LATCH_MIN));
    end else begin
      sec_cnt <= sec_cnt + SW'(1);
      if (latch_pulse && latch_cnt != 2'b11) begin
        latch_cnt <= latch_cnt + 2'b01;
      end
    end
  end

  // Disable masks only the combined alarm
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rotation_rate_alarm <= 1'b0;
      pgen_alarm <= 1'b0;
      combined_antenna_alarm <= 1'b0;
    end else begin
      rotation_rate_alarm <= rot_bad;
      pgen_alarm <= ratio_bad || latch_bad;
      combined_antenna_alarm <= ant_en && (rot_bad || ratio_bad || latch_bad);
    end
  end

  // ************************************************************
  // Built-in test sequence
  // ************************************************************
  localparam int BW = 16;
  localparam int unsigned BER_BITS = `BAM_BER_DEN;
  bam_state_e state;
  bam_state_e next_state;
  logic [BW-1:0] bit_cnt;
  logic [BW-1:0] inter_err;
  logic [BW-1:0] reply_err [NUM_GEN];
  logic seq_done;
  wire bit_last = bit_cnt == BW'(BIT_CYCLES - 1);
  wire inter_fail = inter_err > BW'(BIT_CYCLES / BER_BITS);

  always_comb begin
    next_state = state;
    case (state)
      BAM_IDLE: next_state = start_pulse ? BAM_RUN : BAM_IDLE;
      BAM_RUN: next_state = bit_last ? BAM_DONE : BAM_RUN;
      BAM_DONE: next_state = BAM_IDLE;
      default: next_state = BAM_IDLE;
    endcase
    if (start_pulse) begin
      next_state = BAM_RUN;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= BAM_IDLE;
      bit_cnt <= '0;
      inter_err <= '0;
      seq_done <= 1'b0;
      test_busy <= 1'b0;
    end else begin
      state <= next_state;
      seq_done <= (state == BAM_DONE);
      test_busy <= (next_state != BAM_IDLE);
      if (start_pulse) begin
        bit_cnt <= '0;
        inter_err <= '0;
      end else if (state == BAM_RUN) begin
        bit_cnt <= bit_cnt + BW'(1);
        if (inter_bit_err) begin
          inter_err <= inter_err + BW'(1);
        end
      end
    end
  end

  bam_bit_s flags [NUM_GEN];
  generate
    for (genvar g = 0; g < NUM_GEN; g++) begin : gen_rg
      bam_step_if st();
      assign st.dlt_up_ok = dlt_up_ok[g*5 +: 5];
      assign st.omni_up_ok = omni_up_ok[g*5 +: 5];
      assign st.sum_up_ok = sum_up_ok[g*5 +: 5];
      assign st.tlvl_ok = tlvl_ok[g*9 +: 9];
      assign st.so_ok = so_ok[g*6 +: 6];
      assign st.dsr_ok = dsr_ok[g*8 +: 8];
      assign st.aux_ok = aux_ok[g*6 +: 6];
      assign st.phase_ok = phase_ok[g];
      assign st.ampl_ok = ampl_ok[g];
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          reply_err[g] <= '0;
        end else if (start_pulse) begin
          reply_err[g] <= '0;
        end else if (state == BAM_RUN && reply_bit_err[g]) begin
          reply_err[g] <= reply_err[g] + BW'(1);
        end
      end
      bam_bit_eval u_eval (
        .clk(clk),
        .rst(rst),
        .load(seq_done),
        .st(st),
        .load_bad(load_bad),
        .ber_reply_fail(reply_err[g] > BW'(BIT_CYCLES / BER_BITS)),
        .ber_inter_fail(inter_fail),
        .cal_sum_bad(cal_sum_bad),
        .prog_sum_bad(prog_sum_bad),
        .flags(flags[g])
      );
    end
  endgenerate

  // ************************************************************
  // Register read
  // ************************************************************
  // One bit per indicator
  wire [31:0] equip_word = {26'h0, combined_antenna_alarm, pgen_alarm,
    rotation_rate_alarm, cal_alarm, temp_alarm, power_alarm};
  wire [31:0] rd_mux =
    (addr == `BAM_REG_CTRL) ? {ctrl[31:5], test_busy, ctrl[3:0]} :
    (addr == `BAM_REG_EQUIP) ? equip_word :
    (addr == `BAM_REG_BIT0) ? {18'h0, flags[0]} :
    (addr == `BAM_REG_BIT1 && NUM_GEN > 1) ? {18'h0, flags[NUM_GEN-1]} :
    (addr == `BAM_REG_ROT) ? {16'h0, chg_cnt} :
    (addr == `BAM_REG_LIMIT) ? {14'h0, latch_cnt, inter_err} :
    32'h0;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= '0;
    end else begin
      rdata <= rd ? rd_mux : 32'h0;
    end
  end

  a_ant_comb: assert property (@(posedge clk) disable iff (rst)
    rotation_rate_alarm && $past(ant_en) |-> combined_antenna_alarm)
    else $error("rotation alarm missed combined");
  a_pgen_comb: assert property (@(posedge clk) disable iff (rst)
    pgen_alarm && $past(ant_en) |-> combined_antenna_alarm)
    else $error("pulse alarm missed combined");
  a_ant_masked: assert property (@(posedge clk) disable iff (rst)
    !$past(ant_en) |-> !combined_antenna_alarm)
    else $error("combined alarm while disabled");
  a_power_eval: assert property (@(posedge clk) disable iff (rst)
    equip_pulse |=> power_alarm == $past(next_power))
    else $error("power alarm wrong");
  a_temp_eval: assert property (@(posedge clk) disable iff (rst)
    equip_pulse && temp_c > 8'sd65 |=> temp_alarm)
    else $error("over temperature missed");
  a_cal_eval: assert property (@(posedge clk) disable iff (rst)
    equip_pulse |=> cal_alarm == $past(comp_fail))
    else $error("calibration alarm wrong");
  sequence s_start;
    start_pulse ##1 test_busy;
  endsequence
  a_seq_start: assert property (@(posedge clk) disable iff (rst)
    s_start |-> state == BAM_RUN) else $error("sequence not running");
  a_ratio_ok: assert property (@(posedge clk) disable iff (rst)
    azimuth_reference_pulse && ref_seen && chg_cnt == 16'd4096
    |=> !ratio_bad) else $error("good ratio flagged");
  a_rot_stall: assert property (@(posedge clk) disable iff (rst)
    rev_over && !azimuth_reference_pulse |=> rot_bad)
    else $error("stalled antenna missed");
  a_latch_chk: assert property (@(posedge clk) disable iff (rst)
    sec_end && phased && latch_cnt == 2'd0 |=> latch_bad)
    else $error("missing latch pulses not flagged");
endmodule

// ---- verilog/bam_pkg.sv ----
package bam_pkg;
  typedef enum logic [1:0] {
    BAM_IDLE,
    BAM_RUN,
    BAM_DONE
  } bam_state_e;
  // One full set of test results for a reply generator
  typedef struct packed {
    logic delta_upconverter;
    logic omni_upconverter;
    logic sum_upconverter;
    logic target_level_attenuator;
    logic sum_omni_ratio;
    logic delta_sum_ratio_attenuator;
    logic aux_delta_sum_attenuator;
    logic phase_mod;
    logic pulse_amplitude_modulator;
    logic load_bad;
    logic ber_reply;
    logic ber_inter;
    logic cal_flash;
    logic prog_rom;
  } bam_bit_s;
endpackage

// ---- verilog/bam_step_if.sv ----
// Step results of one reply generator toward the evaluator
interface bam_step_if;
  logic [4:0] dlt_up_ok;
  logic [4:0] omni_up_ok;
  logic [4:0] sum_up_ok;
  logic [8:0] tlvl_ok;
  logic [5:0] so_ok;
  logic [7:0] dsr_ok;
  logic [5:0] aux_ok;
  logic phase_ok;
  logic ampl_ok;
  modport src(output dlt_up_ok, omni_up_ok, sum_up_ok, tlvl_ok, so_ok,
    dsr_ok, aux_ok, phase_ok, ampl_ok);
  modport eval(input dlt_up_ok, omni_up_ok, sum_up_ok, tlvl_ok, so_ok,
    dsr_ok, aux_ok, phase_ok, ampl_ok);
endinterface
